//--- rate_converter_pkg.sv
package rate_converter_pkg;

    // ----------------------------------------
    // Sizes
    // ----------------------------------------
    localparam int NUM_UNITS = 8;
    localparam int NUM_SOURCES = 8;
    localparam int NUM_RATES = 4;
    localparam int SAMPLE_W = 24;
    localparam int PERIOD_W = 16;
    localparam int RATIO_W = 16;
    localparam int RATIO_FRAC = 12;
    localparam int ADDR_W = 18;

    // ----------------------------------------
    // Register indices; byte address is four times the index
    // ----------------------------------------
    localparam logic [15:0] IDX_LOCK_STATUS = 16'hf580;
    localparam logic [15:0] IDX_MUTE_CONTROL = 16'hf581;
    localparam logic [15:0] IDX_RATIO_BASE = 16'hf582;
    localparam logic [15:0] IDX_INPUT_SELECT_BASE = 16'hf590;
    localparam logic [15:0] IDX_TARGET_RATE_BASE = 16'hf598;
    localparam logic [15:0] IDX_IRQ_STATUS = 16'hf5a0;
    localparam logic [15:0] IDX_IRQ_ENABLE = 16'hf5a1;
    localparam logic [15:0] IDX_IRQ_CLEAR = 16'hf5a2;

    // ----------------------------------------
    // Reset values and timing counts
    // ----------------------------------------
    localparam logic [7:0] MUTE_RESET = 8'h00;
    localparam logic [2:0] INPUT_SELECT_RESET = 3'h0;
    localparam logic [2:0] TARGET_RATE_RESET = 3'h0;
    localparam logic [15:0] IRQ_ENABLE_RESET = 16'h0000;
    localparam logic [2:0] LOCK_COUNT = 3'h4;
    localparam logic [PERIOD_W-1:0] PERIOD_TOL = 16'h0004;
    localparam logic [PERIOD_W-1:0] PERIOD_MAX = 16'hffff;
    localparam logic [4:0] DIV_STEPS = 5'h1c;

    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef struct packed {
        logic [SAMPLE_W-1:0] left;
        logic [SAMPLE_W-1:0] right;
    } stereo_s;

    typedef enum logic [1:0] {
        ST_SEARCH = 2'b00,
        ST_COUNT = 2'b01,
        ST_LOCKED = 2'b11
    } lock_state_e;

    // Midpoint of two signed samples, the simplest interpolating filter
    function automatic logic [SAMPLE_W-1:0] midpoint(input logic [SAMPLE_W-1:0] a, input logic [SAMPLE_W-1:0] b);
        logic [SAMPLE_W:0] sum;
        sum = {a[SAMPLE_W-1], a} + {b[SAMPLE_W-1], b};
        return sum[SAMPLE_W:1];
    endfunction

    function automatic logic within_tol(input logic [PERIOD_W-1:0] a, input logic [PERIOD_W-1:0] b);
        logic [PERIOD_W-1:0] diff;
        diff = (a > b) ? (a - b) : (b - a);
        return diff <= PERIOD_TOL;
    endfunction

endpackage

//--- rate_converter_routing_model.sv
module rate_converter_routing_model
    import rate_converter_pkg::*;
(
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_resetn,
    // Streams toward the converters
    output logic [NUM_SOURCES-1:0] o_source_frame,
    output stereo_s [NUM_SOURCES-1:0] o_source_sample,
    output logic [NUM_RATES-1:0] o_target_frame
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] scnt [NUM_SOURCES];
    logic [15:0] step [NUM_SOURCES];
    logic [7:0] tcnt [NUM_RATES];

    // Each source has its own period so units see unlike rates
    // shared pair clock
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            for (int s = 0; s < NUM_SOURCES; s++) begin
                scnt[s] <= 8'h00;
                step[s] <= 16'h0000;
                o_source_frame[s] <= 1'b0;
                o_source_sample[s] <= '0;
            end
            for (int r = 0; r < NUM_RATES; r++) begin
                tcnt[r] <= 8'h00;
                o_target_frame[r] <= 1'b0;
            end
        end else begin
            for (int s = 0; s < NUM_SOURCES; s++) begin
                scnt[s] <= (scnt[s] == 8'(39 + 4 * s)) ? 8'h00 : scnt[s] + 8'h01;
                o_source_frame[s] <= scnt[s] < 8'(20 + 2 * s);
                // Data moves at the falling edge, far from the sampling edge
                if (scnt[s] == 8'(20 + 2 * s)) begin
                    step[s] <= step[s] + 16'h0001;
                    o_source_sample[s].left <= {1'b0, 3'(s), 4'h0, step[s] << 4};
                    o_source_sample[s].right <= -{1'b0, 3'(s), 4'h0, step[s] << 4};
                end
            end
            for (int r = 0; r < NUM_RATES; r++) begin
                tcnt[r] <= (tcnt[r] == 8'(63 + 16 * r)) ? 8'h00 : tcnt[r] + 8'h01;
                o_target_frame[r] <= tcnt[r] < 8'(32 + 8 * r);
            end
        end
    end
endmodule // rate_converter_routing_model

//--- rate_converter_unit.sv
module rate_converter_unit
    import rate_converter_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic i_in_edge,
    input wire stereo_s i_in_sample,
    input wire logic i_out_edge,
    input wire logic i_rate_valid,
    input wire logic i_mute,
    output stereo_s o_sample,
    output logic o_valid,
    output logic o_lock,
    output logic [RATIO_W-1:0] o_ratio
);

    logic [PERIOD_W-1:0] in_cnt;
    logic [PERIOD_W-1:0] in_period;
    logic [PERIOD_W-1:0] out_cnt;
    logic [PERIOD_W-1:0] out_period;
    stereo_s prev;
    stereo_s cur;
    lock_state_e state;
    lock_state_e next_state;
    logic [2:0] good_cnt;
    logic [2:0] next_good_cnt;
    logic [27:0] div_num;
    logic [16:0] div_rem;
    logic [4:0] div_step;
    logic div_busy;

    wire in_lost = (in_cnt == PERIOD_MAX);
    wire out_lost = (out_cnt == PERIOD_MAX);
    wire in_match = within_tol(in_cnt, in_period);
    wire rate_ok = i_rate_valid && (out_period != '0) && !out_lost;
    wire [16:0] trial = {div_rem[15:0], div_num[27]};
    wire trial_ge = trial >= {1'b0, in_period};
    wire [16:0] trial_sub = trial - {1'b0, in_period};

    // ----------------------------------------
    // Lock sequence
    // ----------------------------------------
    // Lock qualification
    always_comb begin
        next_state = state;
        next_good_cnt = good_cnt;
        case (state)
            ST_SEARCH: begin
                if (i_in_edge && in_period != '0) begin
                    next_state = ST_COUNT;
                    next_good_cnt = '0;
                end
            end
            ST_COUNT: begin
                if (i_in_edge) begin
                    next_good_cnt = in_match ? good_cnt + 3'h1 : '0;
                    if (in_match && good_cnt == LOCK_COUNT - 3'h1 && rate_ok) begin
                        next_state = ST_LOCKED;
                    end
                end
            end
            ST_LOCKED: begin
                if (i_in_edge && !in_match) begin
                    next_state = ST_COUNT;
                    next_good_cnt = '0;
                end
            end
            default: next_state = ST_SEARCH;
        endcase
        if (in_lost || !rate_ok && state == ST_LOCKED) begin
            next_state = ST_SEARCH;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_SEARCH;
            good_cnt <= '0;
            o_lock <= 1'b0;
        end else begin
            state <= next_state;
            good_cnt <= next_good_cnt;
            o_lock <= (next_state == ST_LOCKED);
        end
    end

    // ----------------------------------------
    // Period measurement and sample history
    // ----------------------------------------
    // Input and output rate measurement
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            in_cnt <= '0;
            in_period <= '0;
            out_cnt <= '0;
            out_period <= '0;
            prev <= '0;
            cur <= '0;
        end else begin
            in_cnt <= i_in_edge ? 16'h0001 : (in_lost ? in_cnt : in_cnt + 16'h0001);
            out_cnt <= i_out_edge ? 16'h0001 : (out_lost ? out_cnt : out_cnt + 16'h0001);
            if (i_in_edge) begin
                in_period <= in_lost ? '0 : in_cnt;
                prev <= cur;
                cur <= i_in_sample;
            end
            if (i_out_edge) begin
                out_period <= out_lost ? '0 : out_cnt;
            end
        end
    end

    // ----------------------------------------
    // Output, both channels taken on the same edge
    // ----------------------------------------
    // Shared stereo timing
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            o_sample <= '0;
            o_valid <= 1'b0;
        end else begin
            o_valid <= i_out_edge;
            if (i_out_edge) begin
                o_sample.left <= i_mute ? '0 : midpoint(prev.left, cur.left);
                o_sample.right <= i_mute ? '0 : midpoint(prev.right, cur.right);
            end
        end
    end

    // ----------------------------------------
    // Ratio out_period / in_period, serial long division
    // ----------------------------------------
    // Ratio measurement
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_num <= '0;
            div_rem <= '0;
            div_step <= '0;
            div_busy <= 1'b0;
            o_ratio <= '0;
        end else if (!div_busy) begin
            if (i_in_edge && in_period != '0 && out_period != '0) begin
                div_num <= {out_period, 12'h000};
                div_rem <= '0;
                div_step <= '0;
                div_busy <= 1'b1;
            end
        end else if (div_step == DIV_STEPS) begin
            div_busy <= 1'b0;
            o_ratio <= (|div_num[27:16]) ? 16'hffff : div_num[15:0];
        end else begin
            div_rem <= trial_ge ? trial_sub : trial;
            div_num <= {div_num[26:0], trial_ge};
            div_step <= div_step + 5'h01;
        end
    end

endmodule // rate_converter_unit

//--- stereo_rate_converter_bank.sv
module stereo_rate_converter_bank
    import rate_converter_pkg::*;
(
    // Clock and reset
    input wire logic I_CLOCK,
    input wire logic I_RESETN,
    // APB slave
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [ADDR_W-1:0] I_PADDR,
    input wire logic [31:0] I_PWDATA,
    output logic [31:0] O_PRDATA,
    output logic O_PREADY,
    output logic O_PSLVERR,
    // Audio sources from the routing fabric
    input wire logic [NUM_SOURCES-1:0] I_SOURCE_FRAME,
    input wire stereo_s [NUM_SOURCES-1:0] I_SOURCE_SAMPLE,
    // Target rate frame clocks
    input wire logic [NUM_RATES-1:0] I_TARGET_FRAME,
    // Converted audio to the processing core
    output stereo_s [NUM_UNITS-1:0] O_CONVERTED_SAMPLE,
    output logic [NUM_UNITS-1:0] O_CONVERTED_VALID,
    // Interrupt
    output logic O_IRQ
);

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    logic [NUM_SOURCES-1:0] src_meta;
    logic [NUM_SOURCES-1:0] src_sync;
    logic [NUM_SOURCES-1:0] src_prev;
    logic [NUM_RATES-1:0] rate_meta;
    logic [NUM_RATES-1:0] rate_sync;
    logic [NUM_RATES-1:0] rate_prev;
    logic [7:0] converter_mute_control;
    logic [2:0] converter_input_select [NUM_UNITS];
    logic [2:0] converter_target_rate [NUM_UNITS];
    logic [15:0] irq_status;
    logic [15:0] irq_enable;
    logic [NUM_UNITS-1:0] lock_prev;
    logic [NUM_UNITS-1:0] unit_lock;
    logic [RATIO_W-1:0] unit_ratio [NUM_UNITS];
    logic [NUM_UNITS-1:0] unit_in_edge;
    logic [NUM_UNITS-1:0] unit_out_edge;
    logic [NUM_UNITS-1:0] unit_rate_valid;
    stereo_s unit_in_sample [NUM_UNITS];

    function automatic logic in_block(input logic [15:0] idx, input logic [15:0] base);
        return (idx >= base) && (idx < base + 16'h0008);
    endfunction

    // ----------------------------------------
    // Frame clock synchronisers
    // ----------------------------------------
    // Sample words are taken one clock after the synchronised rising frame
    // edge; the source must hold them steady for that long.
    always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            src_meta <= '0;
            src_sync <= '0;
            src_prev <= '0;
            rate_meta <= '0;
            rate_sync <= '0;
            rate_prev <= '0;
        end else begin
            src_meta <= I_SOURCE_FRAME;
            src_sync <= src_meta;
            src_prev <= src_sync;
            rate_meta <= I_TARGET_FRAME;
            rate_sync <= rate_meta;
            rate_prev <= rate_sync;
        end
    end

    wire [NUM_SOURCES-1:0] src_edge = src_sync & ~src_prev;
    wire [NUM_RATES-1:0] rate_edge = rate_sync & ~rate_prev;

    // ----------------------------------------
    // APB decode
    // ----------------------------------------
    wire [15:0] reg_idx = I_PADDR[17:2];
    wire [2:0] reg_unit = reg_idx[2:0];
    wire word_aligned = (I_PADDR[1:0] == 2'b00);
    wire access_phase = I_PSEL && I_PENABLE;
    wire data_phase = access_phase && !O_PREADY;
    wire write_done = access_phase && O_PREADY && I_PWRITE;
    wire hit_lock = (reg_idx == IDX_LOCK_STATUS);
    wire hit_mute = (reg_idx == IDX_MUTE_CONTROL);
    wire hit_ratio = in_block(reg_idx, IDX_RATIO_BASE);
    wire hit_select = in_block(reg_idx, IDX_INPUT_SELECT_BASE);
    wire hit_rate = in_block(reg_idx, IDX_TARGET_RATE_BASE);
    wire hit_irq_status = (reg_idx == IDX_IRQ_STATUS);
    wire hit_irq_enable = (reg_idx == IDX_IRQ_ENABLE);
    wire hit_irq_clear = (reg_idx == IDX_IRQ_CLEAR);
    wire [2:0] ratio_unit = 3'(reg_idx - IDX_RATIO_BASE);
    wire read_ok = word_aligned && (hit_lock || hit_mute || hit_ratio || hit_select
                                    || hit_rate || hit_irq_status || hit_irq_enable);
    wire write_ok = word_aligned && (hit_mute || hit_select || hit_rate
                                     || hit_irq_enable || hit_irq_clear);
    wire access_ok = I_PWRITE ? write_ok : read_ok;

    logic [31:0] read_mux;
    always_comb begin
        read_mux = '0;
        if (hit_lock) begin
            read_mux[7:0] = unit_lock;
        end else if (hit_mute) begin
            read_mux[7:0] = converter_mute_control;
        end else if (hit_ratio) begin
            read_mux[15:0] = unit_ratio[ratio_unit];
        end else if (hit_select) begin
            read_mux[2:0] = converter_input_select[reg_unit];
        end else if (hit_rate) begin
            read_mux[2:0] = converter_target_rate[reg_unit];
        end else if (hit_irq_status) begin
            read_mux[15:0] = irq_status;
        end else if (hit_irq_enable) begin
            read_mux[15:0] = irq_enable;
        end
    end

    // ----------------------------------------
    // APB response: one wait state so that read data comes from a flop
    // ----------------------------------------
    always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            O_PREADY <= 1'b0;
            O_PRDATA <= '0;
            O_PSLVERR <= 1'b0;
        end else begin
            O_PREADY <= data_phase;
            O_PSLVERR <= data_phase && !access_ok;
            if (data_phase) begin
                O_PRDATA <= (I_PWRITE || !read_ok) ? 32'h0000_0000 : read_mux;
            end
        end
    end

    // ----------------------------------------
    // Control registers
    // ----------------------------------------
    always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            converter_mute_control <= MUTE_RESET;
            irq_enable <= IRQ_ENABLE_RESET;
        end else if (write_done && word_aligned) begin
            if (hit_mute) begin
                converter_mute_control <= I_PWDATA[7:0];
            end
            if (hit_irq_enable) begin
                irq_enable <= I_PWDATA[15:0];
            end
        end
    end

    always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            for (int n = 0; n < NUM_UNITS; n++) begin
                converter_input_select[n] <= INPUT_SELECT_RESET;
                converter_target_rate[n] <= TARGET_RATE_RESET;
            end
        end else if (write_done && word_aligned) begin
            if (hit_select) begin
                converter_input_select[reg_unit] <= I_PWDATA[2:0];
            end
            if (hit_rate) begin
                converter_target_rate[reg_unit] <= I_PWDATA[2:0];
            end
        end
    end

    // ----------------------------------------
    // Interrupts: low byte lock gained, high byte lock lost
    // ----------------------------------------
    wire [7:0] lock_gained = unit_lock & ~lock_prev;
    wire [7:0] lock_lost = ~unit_lock & lock_prev;
    wire [15:0] irq_clear = (write_done && word_aligned && hit_irq_clear) ? I_PWDATA[15:0] : 16'h0000;
    wire [15:0] irq_set = {lock_lost, lock_gained};

    // New events win over a clear in the same cycle
    always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            lock_prev <= '0;
            irq_status <= '0;
            O_IRQ <= 1'b0;
        end else begin
            lock_prev <= unit_lock;
            irq_status <= (irq_status & ~irq_clear) | irq_set;
            O_IRQ <= |(((irq_status & ~irq_clear) | irq_set) & irq_enable);
        end
    end

    // ----------------------------------------
    // Converter units
    // ----------------------------------------
    // Eight stereo units
    genvar u;
    generate
        for (u = 0; u < NUM_UNITS; u++) begin : g_unit
            assign unit_in_edge[u] = src_edge[converter_input_select[u]];
            assign unit_in_sample[u] = I_SOURCE_SAMPLE[converter_input_select[u]];
            assign unit_rate_valid[u] = (converter_target_rate[u] < 3'(NUM_RATES));
            assign unit_out_edge[u] = unit_rate_valid[u] && rate_edge[converter_target_rate[u][1:0]];

            rate_converter_unit u_unit (
                .clk(I_CLOCK),
                .rst_n(I_RESETN),
                .i_in_edge(unit_in_edge[u]),
                .i_in_sample(unit_in_sample[u]),
                .i_out_edge(unit_out_edge[u]),
                .i_rate_valid(unit_rate_valid[u]),
                .i_mute(converter_mute_control[u]),
                .o_sample(O_CONVERTED_SAMPLE[u]),
                .o_valid(O_CONVERTED_VALID[u]),
                .o_lock(unit_lock[u]),
                .o_ratio(unit_ratio[u])
            );
        end
    endgenerate

endmodule // stereo_rate_converter_bank

//--- stereo_rate_converter_bank_chk.sv
module stereo_rate_converter_bank_chk
    import rate_converter_pkg::*;
(
    // Clock and reset
    input wire logic I_CLOCK,
    input wire logic I_RESETN,
    // APB
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic [31:0] O_PRDATA,
    input wire logic O_PREADY,
    input wire logic O_PSLVERR,
    // Converted audio
    input wire stereo_s [NUM_UNITS-1:0] O_CONVERTED_SAMPLE,
    input wire logic [NUM_UNITS-1:0] O_CONVERTED_VALID
);
    default clocking cb @(posedge I_CLOCK);
    endclocking
    default disable iff (!I_RESETN);

    sequence s_setup;
        I_PSEL && !I_PENABLE;
    endsequence
    sequence s_one_wait;
        !O_PREADY ##1 O_PREADY;
    endsequence

    AST_ONE_WAIT: assert property (s_setup |=> s_one_wait)
        else $error("ready not after one wait state");
    AST_READY_PULSE: assert property (O_PREADY |=> !O_PREADY)
        else $error("ready longer than one cycle");
    AST_READY_IN_ACCESS: assert property (O_PREADY |-> I_PSEL && I_PENABLE)
        else $error("ready outside access phase");
    AST_ERR_WITH_READY: assert property (O_PSLVERR |-> O_PREADY)
        else $error("error without ready");
    AST_ERR_DATA_ZERO: assert property (O_PREADY && O_PSLVERR |-> O_PRDATA == 32'h0)
        else $error("refused access returned data");
    AST_RDATA_HOLD: assert property (O_PRDATA != $past(O_PRDATA) |-> O_PREADY)
        else $error("read data moved between transfers");
    AST_VALID_PULSE: assert property ((O_CONVERTED_VALID & $past(O_CONVERTED_VALID)) == '0)
        else $error("output valid longer than one cycle");
    AST_SAMPLE_HOLD: assert property (O_CONVERTED_SAMPLE != $past(O_CONVERTED_SAMPLE) |-> O_CONVERTED_VALID != '0)
        else $error("output sample changed without valid");
endmodule // stereo_rate_converter_bank_chk

bind stereo_rate_converter_bank stereo_rate_converter_bank_chk chk (
    .I_CLOCK(I_CLOCK),
    .I_RESETN(I_RESETN),
    .I_PSEL(I_PSEL),
    .I_PENABLE(I_PENABLE),
    .O_PRDATA(O_PRDATA),
    .O_PREADY(O_PREADY),
    .O_PSLVERR(O_PSLVERR),
    .O_CONVERTED_SAMPLE(O_CONVERTED_SAMPLE),
    .O_CONVERTED_VALID(O_CONVERTED_VALID)
);

//--- stereo_rate_converter_bank_test.sv
module stereo_rate_converter_bank_test
    import rate_converter_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic clock = 1'b0;
    logic rst_n, psel, penable, pwrite, pready, pslverr, irq, err;
    logic chk_en = 1'b0;
    logic [1:0] addr_lo = 2'b00;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [NUM_SOURCES-1:0] src_frame;
    stereo_s [NUM_SOURCES-1:0] src_sample;
    logic [NUM_RATES-1:0] tgt_frame;
    stereo_s [NUM_UNITS-1:0] conv;
    logic [NUM_UNITS-1:0] conv_valid;
    logic [2:0] sel_m [NUM_UNITS];
    logic [2:0] rate_m [NUM_UNITS];
    logic [7:0] mute_m;
    int mismatches = 0;
    int n_compared = 0;
    int cycles = 0;
    int n_out = 0;

    stereo_rate_converter_bank DUT (.I_CLOCK(clock), .I_RESETN(rst_n), .I_PSEL(psel), .I_PENABLE(penable),
        .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
        .O_PSLVERR(pslverr), .I_SOURCE_FRAME(src_frame), .I_SOURCE_SAMPLE(src_sample),
        .I_TARGET_FRAME(tgt_frame), .O_CONVERTED_SAMPLE(conv), .O_CONVERTED_VALID(conv_valid), .O_IRQ(irq));
    rate_converter_routing_model fabric (.i_clock(clock), .i_resetn(rst_n), .o_source_frame(src_frame),
        .o_source_sample(src_sample), .o_target_frame(tgt_frame));

    initial forever #12.5 clock = ~clock;

    // ------
    // Tasks
    // ------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    function automatic logic near(input logic [23:0] a, input logic [23:0] b);
        logic [23:0] d;
        d = a - b;
        return ($signed(d) <= 48) && ($signed(d) >= -48);
    endfunction

    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    task automatic tdone(input string name);
        $display("test %s done", name);
    endtask

    // Request held until ready is seen high at a rising edge
    task automatic apb(input logic w, input logic [15:0] idx, input logic [31:0] wd, output logic [31:0] x,
        output logic e);
        int t;
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {idx, addr_lo};
        pwdata <= wd;
        @(posedge clock);
        penable <= 1'b1;
        t = 0;
        do begin
            @(posedge clock);
            t++;
        end while (pready !== 1'b1 && t < 64);
        if (t >= 64) mismatches++;
        x = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [15:0] idx, input logic [31:0] d);
        logic [31:0] x;
        logic e;
        apb(1'b1, idx, d, x, e);
        check(32'(e), 32'h0);
    endtask

    task automatic rdc(input logic [15:0] idx, input logic [31:0] exp);
        logic [31:0] x;
        logic e;
        apb(1'b0, idx, 32'h0, x, e);
        check(32'(e), 32'h0);
        check(x, exp);
    endtask

    // Polling is bounded; lock takes a few input periods
    task automatic wait_lock(input logic [7:0] exp);
        logic [31:0] x;
        logic e;
        int k;
        k = 0;
        do begin
            apb(1'b0, IDX_LOCK_STATUS, 32'h0, x, e);
            k++;
        end while (x[7:0] !== exp && k < 400);
        check(x, {24'h0, exp});
    endtask

    // ------
    // Output monitor
    // ------
    always @(negedge clock) begin
        if (chk_en) begin
            for (int n = 0; n < NUM_UNITS; n++) begin
                if (conv_valid[n] === 1'b1) begin
                    n_out++;
                    if (rate_m[n] > 3'h3) check(32'h1, 32'h0);
                    else if (mute_m[n]) check(32'(conv[n].left | conv[n].right), 32'h0);
                    else check(32'({near(conv[n].left, src_sample[sel_m[n]].left),
                        near(conv[n].right, src_sample[sel_m[n]].right)}), 32'h3);
                end
            end
        end
    end

    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            finish_test();
        end
    end

    initial begin
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = 32'h0;
        mute_m = 8'h00;
        for (int n = 0; n < NUM_UNITS; n++) begin
            sel_m[n] = 3'h0;
            rate_m[n] = 3'h0;
        end
        repeat (8) @(posedge clock);
        rst_n <= 1'b1;
        rdc(IDX_LOCK_STATUS, 32'h0);
        rdc(IDX_MUTE_CONTROL, 32'h0);
        rdc(IDX_IRQ_STATUS, 32'h0);
        rdc(IDX_IRQ_ENABLE, 32'h0);
        for (int n = 0; n < NUM_UNITS; n++) begin
            rdc(IDX_INPUT_SELECT_BASE + 16'(n), 32'h0);
            rdc(IDX_TARGET_RATE_BASE + 16'(n), 32'h0);
        end
        apb(1'b0, IDX_RATIO_BASE + 16'h8, 32'h0, rd, err);
        check(32'(err), 32'h1);
        check(rd, 32'h0);
        apb(1'b1, IDX_LOCK_STATUS, 32'hff, rd, err);
        check(32'(err), 32'h1);
        apb(1'b0, IDX_IRQ_CLEAR, 32'h0, rd, err);
        check(32'(err), 32'h1);
        addr_lo = 2'b10;
        apb(1'b1, IDX_MUTE_CONTROL, 32'hff, rd, err);
        addr_lo = 2'b00;
        check(32'(err), 32'h1);
        rdc(IDX_MUTE_CONTROL, 32'h0);
        wr(IDX_MUTE_CONTROL, 32'hffff_ff5a);
        rdc(IDX_MUTE_CONTROL, 32'h5a);
        wr(IDX_MUTE_CONTROL, 32'h0);
        tdone("registers");
        for (int n = 0; n < NUM_UNITS; n++) begin
            sel_m[n] = 3'(7 - n);
            rate_m[n] = 3'(n % 4);
            wr(IDX_INPUT_SELECT_BASE + 16'(n), 32'(sel_m[n]));
            wr(IDX_TARGET_RATE_BASE + 16'(n), 32'(rate_m[n]));
        end
        for (int n = 0; n < NUM_UNITS; n++) begin
            rdc(IDX_INPUT_SELECT_BASE + 16'(n), 32'(sel_m[n]));
            rdc(IDX_TARGET_RATE_BASE + 16'(n), 32'(rate_m[n]));
        end
        wr(IDX_IRQ_ENABLE, 32'h00ff);
        wait_lock(8'hff);
        rdc(IDX_IRQ_STATUS, 32'h00ff);
        check(32'(irq), 32'h1);
        chk_en = 1'b1;
        repeat (800) @(posedge clock);
        check(32'(n_out >= 48), 32'h1);
        for (int n = 0; n < NUM_UNITS; n++) begin
            apb(1'b0, IDX_RATIO_BASE + 16'(n), 32'h0, rd, err);
            check(32'(near(rd[23:0], 24'((64 + 16 * (n % 4)) * 4096 / (40 + 4 * (7 - n))))), 32'h1);
        end
        tdone("routing");
        chk_en = 1'b0;
        mute_m = 8'h55;
        wr(IDX_MUTE_CONTROL, 32'h55);
        repeat (300) @(posedge clock);
        chk_en = 1'b1;
        repeat (600) @(posedge clock);
        chk_en = 1'b0;
        mute_m = 8'h00;
        wr(IDX_MUTE_CONTROL, 32'h0);
        tdone("mute");
        wr(IDX_IRQ_CLEAR, 32'hffff);
        rdc(IDX_IRQ_STATUS, 32'h0);
        check(32'(irq), 32'h0);
        wr(IDX_IRQ_ENABLE, 32'h0100);
        rate_m[0] = 3'h4;
        wr(IDX_TARGET_RATE_BASE, 32'h4);
        wait_lock(8'hfe);
        rdc(IDX_IRQ_STATUS, 32'h0100);
        check(32'(irq), 32'h1);
        wr(IDX_IRQ_ENABLE, 32'h0);
        repeat (2) @(posedge clock);
        check(32'(irq), 32'h0);
        wr(IDX_IRQ_CLEAR, 32'h0100);
        rdc(IDX_IRQ_STATUS, 32'h0);
        chk_en = 1'b1;
        repeat (600) @(posedge clock);
        tdone("interrupt");
        finish_test();
    end
endmodule // stereo_rate_converter_bank_test
